// >>> inc/edt_pkg.sv
// Constants, state encoding and tick conversion for the edge-triggered timer.
// Assumes a shared system timer that pulses once per tick period.
`default_nettype none
package edt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [31:0] EDT_MS_PER_SEC     = 32'h0000_03E8;
  localparam logic [31:0] EDT_TICK_PERIOD_MS = 32'h0000_0001;
  localparam logic [31:0] EDT_TICKS_PER_SEC  = EDT_MS_PER_SEC / EDT_TICK_PERIOD_MS;
  localparam logic [31:0] EDT_MIN_TICKS      = 32'h0000_0001;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          EDT_SEC_W     = 16;
  localparam int          EDT_CNT_W     = 32;
  localparam logic [31:0] EDT_CNT_RST   = 32'h0000_0000;
  localparam logic        EDT_OUT_RST   = 1'h0;
  localparam logic        EDT_MODE_RST  = 1'h0;

  // Gray order along idle, run, pulse
  typedef enum logic [1:0] {
    EDT_IDLE  = 2'h0,
    EDT_RUN   = 2'h1,
    EDT_PULSE = 2'h3
  } edt_state_t;

  // Zero seconds still waits one tick
  function automatic logic [31:0] edt_sec_to_ticks(input logic [15:0] sec);
    logic [31:0] t;
    t = 32'(32'(sec) * EDT_TICKS_PER_SEC);
    return (t == EDT_CNT_RST) ? EDT_MIN_TICKS : t;
  endfunction

endpackage
`default_nettype wire

// >>> src/edt_edge.sv
// Rising-edge detector for the trigger input.
// Assumes the trigger comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module edt_edge (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic level_in,
  output var  logic rise_out
);
  import edt_pkg::*;

  logic prev;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev     <= 1'h0;
      rise_out <= 1'h0;
    end else begin
      prev     <= level_in;
      // Steady levels produce no pulse, except a level already high when reset releases
      rise_out <= level_in & ~prev;
    end
  end

endmodule
`default_nettype wire

// >>> src/edt_timer.sv
// Edge-triggered delay / stretch timer.
// Assumes trigger and tick both come from logic on clk_in.
//
// How it works
// RULE1: only a rising trigger edge starts timing
// RULE2: postponed mode emits one pulse after interval
// RULE3: stretch mode holds output for whole interval
// RULE4: mode input selects stretch or postponed per trigger
// RULE5: ignore policy drops edges while interval runs
// RULE6: restart policy clears elapsed count on edge
// RULE7: interval given in seconds, converted to ticks
// RULE8: elapsed count advances only on system ticks
// RULE9: postponed output pulse lasts one tick
// RULE10: reset clears output, count, returns idle
`timescale 1ns/100ps
`default_nettype none
module edt_timer (
  input  wire logic                          clk_in,
  input  wire logic                          arst_n_in,
  input  wire logic                          trig_in,
  input  wire logic                          tick_in,
  input  wire logic                          hold_mode_in,
  input  wire logic                          restart_on_edge_in,
  input  wire logic [edt_pkg::EDT_SEC_W-1:0] delay_sec_in,
  output var  logic                          timer_out,
  output var  logic                          busy_out
);
  import edt_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  edt_state_t           state;
  logic                 rise;
  logic                 hold_lat;
  logic [EDT_CNT_W-1:0] elapsed;
  logic [EDT_CNT_W-1:0] target;
  logic [EDT_CNT_W-1:0] elapsed_inc;
  logic                 start;
  logic                 restart;
  logic                 done;
  logic                 pulse_end;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  // RULE1: edge not level
  edt_edge u_edge (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .level_in  (trig_in),
    .rise_out  (rise)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign elapsed_inc = elapsed + EDT_MIN_TICKS;
  assign start       = (state == EDT_IDLE) && rise;
  // RULE6: restart on edge
  assign restart     = (state == EDT_RUN) && rise && restart_on_edge_in;
  // RULE8: tick-paced completion
  assign done        = (state == EDT_RUN) && tick_in && !restart && (elapsed_inc >= target);
  assign pulse_end   = (state == EDT_PULSE) && tick_in;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // RULE10: reset to idle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= EDT_IDLE;
    end else begin
      unique case (state)
        EDT_IDLE: begin
          if (start) begin
            state <= EDT_RUN;
          end
        end
        EDT_RUN: begin
          // RULE4: mode picks the ending
          if (done) begin
            state <= hold_lat ? EDT_IDLE : EDT_PULSE;
          end
        end
        EDT_PULSE: begin
          // RULE9: one tick wide
          if (pulse_end) begin
            state <= EDT_IDLE;
          end
        end
        default: begin
          state <= EDT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Per-trigger settings
  // ----------------------------------------
  // Latched so a mid-interval change cannot cut a running interval short
  // RULE7: seconds to ticks
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_lat <= EDT_MODE_RST;
      target   <= EDT_MIN_TICKS;
    end else if (start) begin
      hold_lat <= hold_mode_in;
      target   <= edt_sec_to_ticks(delay_sec_in);
    end
  end

  // ----------------------------------------
  // Elapsed count
  // ----------------------------------------
  // RULE5: ignored edges leave count alone
  // RULE8: count on ticks only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      elapsed <= EDT_CNT_RST;
    end else if (start || restart || done) begin
      elapsed <= EDT_CNT_RST;
    end else if ((state == EDT_RUN) && tick_in) begin
      elapsed <= elapsed_inc;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // RULE2: delayed single pulse
  // RULE3: stretch held active
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timer_out <= EDT_OUT_RST;
    end else if (start) begin
      timer_out <= hold_mode_in;
    end else if (done) begin
      timer_out <= !hold_lat;
    end else if (pulse_end) begin
      timer_out <= EDT_OUT_RST;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_out <= 1'h0;
    end else if (start) begin
      busy_out <= 1'h1;
    end else if ((done && hold_lat) || pulse_end) begin
      busy_out <= 1'h0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_level_no_start;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_IDLE) && !rise |=> (state == EDT_IDLE) && !timer_out;
  endproperty
  a_level_no_start: assert property (p_level_no_start) else $error("Timer started without edge"); // RULE1

  property p_delay_pulse;
    @(posedge clk_in) disable iff (!arst_n_in)
      done && !hold_lat |=> (state == EDT_PULSE) && timer_out;
  endproperty
  a_delay_pulse: assert property (p_delay_pulse) else $error("Postponed pulse missing"); // RULE2

  // A tick may end a one-tick stretch right after start, so hold is checked per cycle
  property p_stretch_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_RUN) && hold_lat |-> timer_out && busy_out;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("Stretch output dropped early"); // RULE3

  property p_stretch_end;
    @(posedge clk_in) disable iff (!arst_n_in)
      done && hold_lat |=> !timer_out && !busy_out && (state == EDT_IDLE);
  endproperty
  a_stretch_end: assert property (p_stretch_end) else $error("Stretch output not released"); // RULE3

  property p_mode_latched;
    @(posedge clk_in) disable iff (!arst_n_in)
      start |=> (hold_lat == $past(hold_mode_in)) && (timer_out == $past(hold_mode_in));
  endproperty
  a_mode_latched: assert property (p_mode_latched) else $error("Mode not followed"); // RULE4

  property p_ignore_edge;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_RUN) && rise && !restart_on_edge_in && !tick_in |=> $stable(elapsed);
  endproperty
  a_ignore_edge: assert property (p_ignore_edge) else $error("Ignored edge changed count"); // RULE5

  property p_restart_edge;
    @(posedge clk_in) disable iff (!arst_n_in)
      restart |=> (elapsed == EDT_CNT_RST) && (state == EDT_RUN);
  endproperty
  a_restart_edge: assert property (p_restart_edge) else $error("Restart did not clear count"); // RULE6

  property p_target_conv;
    @(posedge clk_in) disable iff (!arst_n_in)
      start |=> target == (($past(delay_sec_in) == '0) ? EDT_MIN_TICKS
                                                       : 32'($past(delay_sec_in)) * EDT_TICKS_PER_SEC);
  endproperty
  a_target_conv: assert property (p_target_conv) else $error("Interval conversion wrong"); // RULE7

  property p_tick_only;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_RUN) && !tick_in && !rise |=> $stable(elapsed) && (state == EDT_RUN);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("Count moved without tick"); // RULE8

  property p_pulse_width;
    @(posedge clk_in) disable iff (!arst_n_in)
      pulse_end |=> !timer_out && (state == EDT_IDLE);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("Pulse wider than one tick"); // RULE9

  property p_idle_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_IDLE) |-> !timer_out && !busy_out && (elapsed == EDT_CNT_RST);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Idle with active output"); // RULE10

  property p_cov_delay;
    @(posedge clk_in) disable iff (!arst_n_in) pulse_end;
  endproperty
  c_cov_delay: cover property (p_cov_delay);

  property p_cov_stretch;
    @(posedge clk_in) disable iff (!arst_n_in) done && hold_lat;
  endproperty
  c_cov_stretch: cover property (p_cov_stretch);

  property p_cov_restart;
    @(posedge clk_in) disable iff (!arst_n_in) restart;
  endproperty
  c_cov_restart: cover property (p_cov_restart);

  property p_cov_ignore;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state == EDT_RUN) && rise && !restart_on_edge_in;
  endproperty
  c_cov_ignore: cover property (p_cov_ignore);

endmodule
`default_nettype wire

// >>> testbench/edt_src.sv
// Upstream logic model: holds the trigger high for a set number of cycles.
// Assumes the bench pulses go_in for one cycle on clk_in.
`timescale 1ns/100ps
`default_nettype none
module edt_src (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       go_in,
  input  wire logic [7:0] len_in,
  output var  logic       trig_out
);
  logic [7:0] left;

  // Plain logic level, so it drops to 0 once released
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      left <= 8'h00;
    end else if (go_in) begin
      left <= len_in;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  always_comb begin
    trig_out = (left != 8'h00);
  end
endmodule
`default_nettype wire

// >>> testbench/edt_timer_tb.sv
// Bench for edt_timer: one task per scenario.
// Assumes edt_src drives the trigger; ticks come every 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module edt_timer_tb;
  import edt_pkg::*;
  logic        clk_in, arst_n_in, tick_in, hold, rst_e, go, tick_en;
  logic        trig, t_out, busy, prev;
  logic [15:0] sec;
  logic [7:0]  len;
  int          n_mismatch, checks, rises, hi_cyc, tdiv;
  int          base_hi, base_rise;

  edt_src u_src (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go),
    .len_in(len), .trig_out(trig));
  edt_timer u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .trig_in(trig),
    .tick_in(tick_in), .hold_mode_in(hold), .restart_on_edge_in(rst_e),
    .delay_sec_in(sec), .timer_out(t_out), .busy_out(busy));

  initial begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Tick source and output monitor
  // ----------------------------------------
  always @(posedge clk_in) begin
    tdiv <= (tdiv + 1) % 4;
    tick_in <= tick_en && (tdiv == 3);
    prev <= t_out;
    if (t_out === 1'h1) hi_cyc <= hi_cyc + 1;
    if (t_out === 1'h1 && prev === 1'h0) rises <= rises + 1;
  end

  task chk(input logic c, input string m);
    checks++;
    if (c !== 1'h1) begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task cfg(input logic h, input logic r, input logic [15:0] s, input logic te);
    @(posedge clk_in);
    hold <= h;
    rst_e <= r;
    sec <= s;
    tick_en <= te;
    @(negedge clk_in);
    // Counters belong to the monitor; scenarios measure from a snapshot
    base_hi = hi_cyc;
    base_rise = rises;
  endtask

  task fire(input logic [7:0] n);
    @(posedge clk_in);
    go <= 1'h1;
    len <= n;
    @(posedge clk_in);
    go <= 1'h0;
  endtask

  task wait_idle;
    int i;
    for (i = 0; i < 10000 && busy !== 1'h0; i++) @(negedge clk_in);
    chk(busy === 1'h0, "busy never dropped");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_stretch;
    cfg(1'h1, 1'h0, 16'h0000, 1'h0);
    fire(8'h03);
    repeat (40) @(negedge clk_in);
    chk(t_out === 1'h1 && busy === 1'h1, "stretch not held");
    @(posedge clk_in) tick_en <= 1'h1;
    wait_idle;
    chk(hi_cyc - base_hi >= 38 && hi_cyc - base_hi <= 50 && rises - base_rise == 1, "stretch width");
  endtask

  task s_postponed;
    cfg(1'h0, 1'h0, 16'h0000, 1'h0);
    fire(8'hC8);
    repeat (20) @(negedge clk_in);
    chk(t_out === 1'h0 && busy === 1'h1, "early pulse");
    @(posedge clk_in) tick_en <= 1'h1;
    repeat (300) @(negedge clk_in);
    chk(rises - base_rise == 1, "pulse count on held level");
    chk(hi_cyc - base_hi == 4, "pulse not one tick");
  endtask

  task s_seconds(input logic r, input int lo, input int hi);
    int w;
    cfg(1'h1, r, 16'h0001, 1'h1);
    fire(8'h02);
    repeat (2000) @(posedge clk_in);
    fire(8'h02);
    wait_idle;
    // Width in clock cycles, four per tick
    w = hi_cyc - base_hi;
    chk(w >= lo && w <= hi && rises - base_rise == 1, "interval length");
  endtask

  task s_reset;
    cfg(1'h1, 1'h0, 16'h0001, 1'h1);
    fire(8'h02);
    repeat (50) @(posedge clk_in);
    arst_n_in <= 1'h0;
    repeat (2) @(negedge clk_in);
    chk(t_out === 1'h0 && busy === 1'h0, "reset ignored");
    @(posedge clk_in) arst_n_in <= 1'h1;
    repeat (20) @(negedge clk_in);
    chk(t_out === 1'h0 && busy === 1'h0, "active after reset");
    fire(8'h02);
    repeat (4) @(posedge clk_in);
    // Mode change after start must not cut the interval
    hold <= 1'h0;
    repeat (20) @(negedge clk_in);
    chk(t_out === 1'h1 && busy === 1'h1, "no fresh start after reset");
  endtask

  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    arst_n_in = 1'h0;
    hold = 1'h0;
    rst_e = 1'h0;
    go = 1'h0;
    tick_en = 1'h0;
    sec = 16'h0000;
    len = 8'h00;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'h1;
    s_stretch;
    s_postponed;
    s_seconds(1'h0, 3996, 4001);
    s_seconds(1'h1, 5994, 6006);
    s_reset;
    final_report;
  end

  // Runs are about 11000 cycles; allow well over twice that
  initial begin
    #150000;
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
